// ===== inc/agp_pkg.sv
// constants for the general pin port: register map, field positions, sync word timing
// assumes one 40 MHz core clock and a command framer outside this block
package agp_pkg;
  localparam logic [7:0] AGP_CFG_ADDR     = 8'h04;
  localparam logic [7:0] AGP_CFG_RESET    = 8'h00;
  localparam logic [7:0] AGP_CFG_WMASK    = 8'h7F;
  localparam int         AGP_NPINS        = 3;
  localparam int         AGP_BIT_RSVD     = 7;
  localparam int         AGP_DIR_LSB      = 4;
  localparam int         AGP_BIT_SEL2     = 3;
  localparam int         AGP_LVL_LSB      = 0;
  localparam logic [7:0] AGP_SYNC_WORD    = 8'h55;
  localparam logic [2:0] AGP_SYNC_FALLS   = 3'h4;
  localparam int         AGP_SYNC_SHIFT   = 3;
  localparam int         AGP_CNT_W        = 20;
  localparam int         AGP_CLK_HZ       = 40_000_000;
endpackage

// ===== hdl/agp_autobaud.sv
// measures the bit period from the synchronisation word on the receive line
// assumes rx_i is already synchronised to core_clk_i; arm_i comes from the command framer
`timescale 1ns/1ps
module agp_autobaud
  import agp_pkg::*;
#(
  parameter int CNT_W = AGP_CNT_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             rx_i,
  input  wire logic             arm_i,
  output logic [CNT_W-1:0]      bit_period_o,
  output logic                  period_valid_o,
  output logic                  sync_error_o
);
  typedef enum logic [1:0] {AB_IDLE, AB_ARMED, AB_MEASURE, AB_DONE} agp_ab_state_t;

  typedef struct packed {
    agp_ab_state_t    st;
    logic             rx_prev;
    logic [2:0]       falls;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    logic             valid;
    logic             err;
  } agp_ab_t;

  agp_ab_t s_q, s_d;
  logic    fall;

  assign fall = s_q.rx_prev & ~rx_i;

  // 55h framed 8-N-1 gives falling edges at bit times 0,2,4,6,8
  always_comb begin
    s_d         = s_q;
    s_d.rx_prev = rx_i;
    s_d.valid   = 1'b0;
    s_d.err     = 1'b0;
    case (s_q.st)
      AB_IDLE: begin
        if (rx_i) begin
          s_d.st = AB_ARMED;
        end
      end
      AB_ARMED: begin
        if (fall) begin
          s_d.st    = AB_MEASURE;
          s_d.cnt   = '0;
          s_d.falls = 3'h0;
        end
      end
      AB_MEASURE: begin
        s_d.cnt = s_q.cnt + 1'b1;
        if (fall) begin
          s_d.falls = s_q.falls + 3'h1;
          if (s_q.falls + 3'h1 == AGP_SYNC_FALLS) begin
            s_d.period = CNT_W'((s_q.cnt + 1'b1) >> AGP_SYNC_SHIFT);
            s_d.valid  = 1'b1;
            s_d.st     = AB_DONE;
          end
        end else if (&s_q.cnt) begin
          s_d.err = 1'b1;
          s_d.st  = AB_IDLE;
        end
      end
      AB_DONE: begin
        if (arm_i) begin
          s_d.st = AB_IDLE;
        end
      end
      default: begin
        s_d.st = AB_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q <= '{st: AB_IDLE, rx_prev: 1'b1, falls: 3'h0, cnt: '0, period: '0, valid: 1'b0, err: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bit_period_o   = s_q.period;
  assign period_valid_o = s_q.valid;
  assign sync_error_o   = s_q.err;

  baud_measure_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (s_q.st == AB_MEASURE && fall && s_q.falls == 3'h3) |=>
      (period_valid_o && bit_period_o == CNT_W'(($past(s_q.cnt) + 1'b1) >> AGP_SYNC_SHIFT)))
    else $error("bit period not taken from sync word");

  sat_error_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (s_q.st == AB_MEASURE && !fall && (&s_q.cnt)) |=> (sync_error_o && !period_valid_o && s_q.st == AB_IDLE))
    else $error("saturated measurement not flagged");
endmodule

// ===== hdl/agp_general_pin_port.sv
// three general pins of the converter with their configuration register
// assumes the command framer presents decoded register accesses on the core clock
//
// Function
// - config register at 04h, resets to 00h
// - bits 6..4 set pin 2..0 direction
// - bit 3 picks level or ready for pin 2
// - bits 2..0 give driven output levels
// - input pins read back their sampled level
// - bit rate measured from the first sync word after each re-arm
// - pin 2 pulled low when result ready
`timescale 1ns/1ps
module agp_general_pin_port
  import agp_pkg::*;
#(
  parameter int NPINS = AGP_NPINS,
  parameter int CNT_W = AGP_CNT_W
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic             reg_wr_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic [7:0]            reg_rdata_o,
  input  wire logic             data_ready_i,
  input  wire logic [NPINS-1:0] pin_in_i,
  output logic [NPINS-1:0]      pin_out_o,
  output logic [NPINS-1:0]      pin_oe_o,
  input  wire logic             uart_rx_i,
  input  wire logic             frame_done_i,
  output logic [CNT_W-1:0]      bit_period_o,
  output logic                  bit_period_valid_o,
  output logic                  sync_error_o
);
  typedef struct packed {
    logic [7:0]       cfg;
    logic [NPINS-1:0] pin_meta;
    logic [NPINS-1:0] pin_sync;
    logic             rx_meta;
    logic             rx_sync;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe;
    logic [7:0]       rdata;
  } agp_port_t;

  agp_port_t s_q, s_d;
  logic      cfg_hit;

  // level bits show the stored value for outputs, the pin for inputs
  function automatic logic [7:0] agp_readback(input logic [7:0] cfg, input logic [NPINS-1:0] pins);
    logic [7:0] r;
    r = cfg;
    r[AGP_BIT_RSVD] = 1'b0;
    for (int i = 0; i < NPINS; i++) begin
      r[AGP_LVL_LSB+i] = cfg[AGP_DIR_LSB+i] ? cfg[AGP_LVL_LSB+i] : pins[i];
    end
    return r;
  endfunction

  assign cfg_hit = (reg_addr_i == AGP_CFG_ADDR);

  // two flops on every pad and on the receive line before anything reads them
  always_comb begin
    s_d          = s_q;
    s_d.pin_meta = pin_in_i;
    s_d.pin_sync = s_q.pin_meta;
    s_d.rx_meta  = uart_rx_i;
    s_d.rx_sync  = s_q.rx_meta;
    // bit 7 is masked on write so it always stores zero
    if (reg_wr_i && cfg_hit) begin
      s_d.cfg = reg_wdata_i & AGP_CFG_WMASK;
    end
    for (int i = 0; i < NPINS; i++) begin
      s_d.pin_oe[i]  = s_d.cfg[AGP_DIR_LSB+i];
      s_d.pin_out[i] = s_d.cfg[AGP_LVL_LSB+i];
    end
    // ready is active high here, the shared pad is active low
    if (s_d.cfg[AGP_BIT_SEL2]) begin
      s_d.pin_out[2] = ~data_ready_i;
    end
    s_d.rdata = cfg_hit ? agp_readback(s_q.cfg, s_q.pin_sync) : 8'h00;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      s_q <= '{cfg: AGP_CFG_RESET, pin_meta: '0, pin_sync: '0, rx_meta: 1'b1, rx_sync: 1'b1,
               pin_out: '0, pin_oe: '0, rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // sync word 55h is assumed from the host; framer re-arms after each command
  agp_autobaud #(
    .CNT_W (CNT_W)
  ) u_autobaud (
    .core_clk_i     (core_clk_i),
    .reset_i        (reset_i),
    .rx_i           (s_q.rx_sync),
    .arm_i          (frame_done_i),
    .bit_period_o   (bit_period_o),
    .period_valid_o (bit_period_valid_o),
    .sync_error_o   (sync_error_o)
  );

  assign reg_rdata_o = s_q.rdata;
  assign pin_out_o   = s_q.pin_out;
  assign pin_oe_o    = s_q.pin_oe;

  cfg_reset_a: assert property (@(posedge core_clk_i)
    reset_i |=> (s_q.cfg == AGP_CFG_RESET && pin_oe_o == '0 && pin_out_o == '0))
    else $error("pins not inputs after reset");

  rsvd_zero_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit) |=> ##1 (reg_rdata_o[AGP_BIT_RSVD] == 1'b0))
    else $error("reserved bit reads nonzero");

  dir_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit) |=> (pin_oe_o == $past(reg_wdata_i[AGP_DIR_LSB +: NPINS])))
    else $error("direction not applied to pins");

  ready_source_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!$past(reset_i) && s_q.cfg[AGP_BIT_SEL2]) |-> (pin_out_o[2] == !$past(data_ready_i)))
    else $error("pin 2 not following ready");

  ready_low_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (data_ready_i && s_q.cfg[AGP_DIR_LSB+2] && s_q.cfg[AGP_BIT_SEL2] && !(reg_wr_i && cfg_hit))
      |=> (pin_oe_o[2] && !pin_out_o[2]))
    else $error("pin 2 not pulled low on ready");

  level_drive_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit && reg_wdata_i[AGP_DIR_LSB+1]) |=>
      (pin_oe_o[1] && pin_out_o[1] == $past(reg_wdata_i[AGP_LVL_LSB+1])))
    else $error("output level not driven");

  input_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cfg_hit && !s_q.cfg[AGP_DIR_LSB]) |=> (reg_rdata_o[AGP_LVL_LSB] == $past(s_q.pin_sync[0])))
    else $error("input level not read back");

  input_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit && !reg_wdata_i[AGP_DIR_LSB] && reg_wdata_i[AGP_LVL_LSB]) |=> !pin_oe_o[0])
    else $error("input pin driven by level write");

  // register write and read checks
  rsvd_store_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit) |=> (s_q.cfg[AGP_BIT_RSVD] == 1'b0))
    else $error("reserved bit stored as one");

  cfg_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit) |=> (s_q.cfg == ($past(reg_wdata_i) & AGP_CFG_WMASK)))
    else $error("config write not stored");

  other_addr_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && !cfg_hit) |=> $stable(s_q.cfg))
    else $error("config changed by other address");

  hold_write_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !reg_wr_i |=> $stable(s_q.cfg))
    else $error("config changed without a write");

  unmapped_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !cfg_hit |=> (reg_rdata_o == 8'h00))
    else $error("unmapped address read nonzero");

  sel_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cfg_hit |=> (reg_rdata_o[AGP_BIT_SEL2] == $past(s_q.cfg[AGP_BIT_SEL2])))
    else $error("source select not read back");

  dir_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    cfg_hit |=> (reg_rdata_o[AGP_DIR_LSB +: NPINS] == $past(s_q.cfg[AGP_DIR_LSB +: NPINS])))
    else $error("direction bits not read back");

  output_read_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cfg_hit && s_q.cfg[AGP_DIR_LSB+1]) |=> (reg_rdata_o[AGP_LVL_LSB+1] == $past(s_q.cfg[AGP_LVL_LSB+1])))
    else $error("output level not read back");

  // pin drive checks
  oe_follow_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    pin_oe_o == s_q.cfg[AGP_DIR_LSB +: NPINS])
    else $error("output enables differ from direction bits");

  level_pin0_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit && reg_wdata_i[AGP_DIR_LSB]) |=>
      (pin_oe_o[0] && pin_out_o[0] == $past(reg_wdata_i[AGP_LVL_LSB])))
    else $error("pin 0 output level not driven");

  level_pin2_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit && reg_wdata_i[AGP_DIR_LSB+2] && !reg_wdata_i[AGP_BIT_SEL2]) |=>
      (pin_oe_o[2] && pin_out_o[2] == $past(reg_wdata_i[AGP_LVL_LSB+2])))
    else $error("pin 2 output level not driven");

  level_hold_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (s_q.cfg[AGP_DIR_LSB+2] && !s_q.cfg[AGP_BIT_SEL2]) |-> (pin_out_o[2] == s_q.cfg[AGP_LVL_LSB+2]))
    else $error("pin 2 level differs from stored bit");

  ready_high_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!data_ready_i && s_q.cfg[AGP_DIR_LSB+2] && s_q.cfg[AGP_BIT_SEL2] && !(reg_wr_i && cfg_hit))
      |=> (pin_oe_o[2] && pin_out_o[2]))
    else $error("pin 2 low without a result");

  input_hold1_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit && !reg_wdata_i[AGP_DIR_LSB+1]) |=> !pin_oe_o[1])
    else $error("input pin 1 driven by level write");

  input_hold2_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (reg_wr_i && cfg_hit && !reg_wdata_i[AGP_DIR_LSB+2]) |=> !pin_oe_o[2])
    else $error("input pin 2 driven by level write");

  // input sampling checks
  input_read1_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cfg_hit && !s_q.cfg[AGP_DIR_LSB+1]) |=> (reg_rdata_o[AGP_LVL_LSB+1] == $past(s_q.pin_sync[1])))
    else $error("input level of pin 1 not read back");

  input_read2_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (cfg_hit && !s_q.cfg[AGP_DIR_LSB+2]) |=> (reg_rdata_o[AGP_LVL_LSB+2] == $past(s_q.pin_sync[2])))
    else $error("input level of pin 2 not read back");

  pin_sync_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (!$past(reset_i) && !$past(reset_i, 2)) |-> (s_q.pin_sync == $past(pin_in_i, 2)))
    else $error("pad level not passed through two flops");
endmodule

// ===== tb/agp_host_model.sv
// host side of the command link: sends the sync byte, 8-N-1, lsb first
// assumes the bench calls send_sync at a rising edge of the core clock
`timescale 1ns/1ps
module agp_host_model
  import agp_pkg::*;
(
  input  wire logic core_clk_i,
  output logic      uart_tx_o
);
  // line idles high between frames
  initial uart_tx_o = 1'b1;
  task automatic send_sync(input int bit_clks);
    logic [9:0] frame;
    frame = {1'b1, AGP_SYNC_WORD, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uart_tx_o <= frame[i];
      repeat (bit_clks) @(posedge core_clk_i);
    end
  endtask
  // line held low past the measurement limit, then back to idle
  task automatic hold_low(input int clks);
    uart_tx_o <= 1'b0;
    repeat (clks) @(posedge core_clk_i);
    uart_tx_o <= 1'b1;
  endtask
endmodule

// ===== tb/agp_general_pin_port_tb.sv
// self-checking bench for the general pin port and its bit-rate measurement
// assumes agp_pkg and the host model are compiled first
`timescale 1ns/1ps
module agp_general_pin_port_tb;
  import agp_pkg::*;
  logic        core_clk_i   = 1'b0;
  logic        reset_i      = 1'b1;
  logic [7:0]  reg_addr_i   = 8'h00;
  logic        reg_wr_i     = 1'b0;
  logic [7:0]  reg_wdata_i  = 8'h00;
  logic        data_ready_i = 1'b0;
  logic        frame_done_i = 1'b0;
  logic [2:0]  pad_ext      = 3'h0;
  logic [11:0] got_period   = 12'h000;
  logic [7:0]  reg_rdata_o;
  logic [2:0]  pin_in_i;
  logic [2:0]  pin_out_o;
  logic [2:0]  pin_oe_o;
  logic        uart_rx_i;
  logic [11:0] bit_period_o;
  logic        bit_period_valid_o;
  logic        sync_error_o;
  int          valid_cnt       = 0;
  int          sync_err_cnt    = 0;
  int          err_total       = 0;
  int          samples_checked = 0;

  // pad level: driven by the port where enabled, else by the board
  assign pin_in_i = (pin_oe_o & pin_out_o) | (~pin_oe_o & pad_ext);
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (bit_period_valid_o === 1'b1) begin
      got_period <= bit_period_o;
      valid_cnt++;
    end
    if (sync_error_o === 1'b1) begin
      sync_err_cnt++;
    end
  end

  agp_general_pin_port #(.CNT_W(12)) dut_u (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .data_ready_i(data_ready_i), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .uart_rx_i(uart_rx_i), .frame_done_i(frame_done_i),
    .bit_period_o(bit_period_o), .bit_period_valid_o(bit_period_valid_o), .sync_error_o(sync_error_o)
  );
  agp_host_model host_u (.core_clk_i(core_clk_i), .uart_tx_o(uart_rx_i));

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    @(posedge core_clk_i);
    #1;
    chk({4'h0, reg_rdata_o}, {4'h0, exp});
  endtask
  task automatic sync_send(input bit rearm, input bit brk, input int clks, input int exp_per, input int exp_cnt,
                           input int exp_err);
    if (rearm) begin
      @(posedge core_clk_i);
      frame_done_i <= 1'b1;
      @(posedge core_clk_i);
      frame_done_i <= 1'b0;
    end
    @(posedge core_clk_i);
    if (brk) begin
      host_u.hold_low(clks);
    end else begin
      host_u.send_sync(clks);
    end
    repeat (4) @(posedge core_clk_i);
    #1;
    chk(got_period, 12'(exp_per));
    chk(12'(valid_cnt), 12'(exp_cnt));
    chk(12'(sync_err_cnt), 12'(exp_err));
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    err_total++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(AGP_CFG_ADDR, 8'h00);
    wr(AGP_CFG_ADDR, 8'h71);
    chk({9'h0, pin_oe_o}, 12'h007);
    chk({9'h0, pin_out_o}, 12'h001);
    rd(AGP_CFG_ADDR, 8'h71);
    rd(8'h05, 8'h00);
    @(posedge core_clk_i);
    pad_ext <= 3'h2;
    wr(AGP_CFG_ADDR, 8'h87);
    chk({9'h0, pin_oe_o}, 12'h000);
    repeat (4) @(posedge core_clk_i);
    rd(AGP_CFG_ADDR, 8'h02);
    @(posedge core_clk_i);
    pad_ext <= 3'h5;
    repeat (4) @(posedge core_clk_i);
    rd(AGP_CFG_ADDR, 8'h05);
    wr(AGP_CFG_ADDR, 8'h48);
    chk({9'h0, pin_oe_o}, 12'h004);
    chk({9'h0, pin_out_o}, 12'h004);
    @(posedge core_clk_i);
    data_ready_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk({11'h0, pin_out_o[2]}, 12'h000);
    wr(AGP_CFG_ADDR, 8'h44);
    chk({11'h0, pin_out_o[2]}, 12'h001);
    sync_send(1'b0, 1'b0, 16, 16, 1, 0);
    sync_send(1'b0, 1'b0, 24, 16, 1, 0);
    sync_send(1'b1, 1'b0, 24, 24, 2, 0);
    sync_send(1'b1, 1'b1, 4200, 24, 2, 1);
    @(posedge core_clk_i);
    pad_ext <= 3'h0;
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    #1;
    chk({9'h0, pin_oe_o}, 12'h000);
    chk(bit_period_o, 12'h000);
    rd(AGP_CFG_ADDR, 8'h00);
    complete_run();
  end
endmodule
